// ---- design/wbc_cache.sv ----
// Purpose: tag lookup, line state, LRU, victim buffer and write buffer of a writeback cache
// Assumes: memory serves accepted writes before later reads; fill beats arrive in order
// Notes: requests are held valid until their ready is seen high
`timescale 1ns/1ps
`include "wbc_regs.svh"
module wbc_cache (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// CPU requestor
	input wire wbc_pkg::wbc_cpu_req_s cpu_req,
	output logic cpu_ready,
	output logic cpu_rvalid,
	output wbc_pkg::wbc_data_t cpu_rdata,
	// Snoop and writeback commands
	input wire wbc_pkg::wbc_maint_req_s maint_req,
	output logic maint_ready,
	output logic maint_done,
	output logic maint_hit,
	// Lower-level read and fill
	output logic mem_rd_valid,
	output wbc_pkg::wbc_addr_t mem_rd_addr,
	input wire logic mem_rd_ready,
	input wire logic fill_valid,
	input wire wbc_pkg::wbc_data_t fill_data,
	// Lower-level write
	output wbc_pkg::wbc_mem_wr_s mem_wr,
	input wire logic mem_wr_ready
);
	import wbc_pkg::*;

	function automatic logic [7:0] frame_idx(input wbc_set_t s, input logic w);
		return {s, w};
	endfunction

	function automatic logic [10:0] word_idx(input wbc_set_t s, input logic w, input wbc_beat_t b);
		return {s, w, b};
	endfunction

	function automatic wbc_data_t merge_bytes(input wbc_data_t old_d, input wbc_data_t new_d, input wbc_be_t be);
		wbc_data_t r;
		r = old_d;
		for (int i = 0; i < `WBC_BE_W; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	wbc_state_e state_r, state_nxt;
	wbc_cpu_req_s req_r;
	logic [`WBC_NFRAMES-1:0] valid_r, dirty_r;
	logic [`WBC_NSETS-1:0] lru_r;
	// Tags live only here; no path exposes them to the CPU
	wbc_tag_t tag_mem [0:`WBC_NFRAMES-1];
	wbc_data_t data_mem [0:`WBC_NWORDS-1];
	wbc_addr_t m_addr_r;
	wbc_cnt_t m_left_r;
	logic m_inv_r, m_hit_r;
	logic vb_valid_r;
	wbc_addr_t vb_addr_r;
	wbc_beat_t vb_beat_r;
	wbc_data_t vb_data_r [0:`WBC_BEATS-1];
	logic wb_valid_r;
	wbc_addr_t wb_addr_r;
	wbc_data_t wb_data_r;
	wbc_be_t wb_be_r;
	wbc_beat_t fill_beat_r;
	logic fill_way_r;

	// Lookup
	wbc_addr_t lk_addr;
	wbc_set_t lk_set;
	wbc_tag_t lk_tag;
	logic hit0, hit1, hit, hit_way, hit_dirty, vict_way;
	always_comb begin
		if (state_r == ST_MAINT) begin
			lk_addr = m_addr_r;
		end else if (state_r == ST_IDLE) begin
			lk_addr = cpu_req.addr;
		end else begin
			lk_addr = req_r.addr;
		end
		lk_set = lk_addr[`WBC_TAG_LSB-1:`WBC_SET_LSB];
		lk_tag = lk_addr[`WBC_ADDR_W-1:`WBC_TAG_LSB];
		hit0 = valid_r[frame_idx(lk_set, 1'b0)] && tag_mem[frame_idx(lk_set, 1'b0)] == lk_tag;
		hit1 = valid_r[frame_idx(lk_set, 1'b1)] && tag_mem[frame_idx(lk_set, 1'b1)] == lk_tag;
		hit = hit0 || hit1;
		hit_way = hit1;
		hit_dirty = dirty_r[frame_idx(lk_set, hit_way)];
		// Invalid frames count as least recently used
		if (!valid_r[frame_idx(lk_set, 1'b0)]) begin
			vict_way = 1'b0;
		end else if (!valid_r[frame_idx(lk_set, 1'b1)]) begin
			vict_way = 1'b1;
		end else begin
			vict_way = lru_r[lk_set];
		end
	end

	// Events
	logic take_cpu, take_maint, rd_hit, wr_hit, port_free, port_wb, wm_active, wm_merge, wm_load;
	logic drained, miss_go, vict_dirty, maint_step, maint_move, vb_load, fill_last;
	wbc_cpu_req_s wm_req;
	always_comb begin
		take_cpu = state_r == ST_IDLE && cpu_ready && cpu_req.valid;
		take_maint = state_r == ST_IDLE && maint_ready && maint_req.valid;
		rd_hit = take_cpu && !cpu_req.we && hit;
		wr_hit = take_cpu && cpu_req.we && hit;
		port_free = !mem_wr.valid || mem_wr_ready;
		port_wb = port_free && !vb_valid_r && wb_valid_r;
		wm_req = (state_r == ST_WMISS) ? req_r : cpu_req;
		wm_active = (take_cpu && cpu_req.we && !hit) || state_r == ST_WMISS;
		wm_merge = wb_valid_r && !port_wb && wb_addr_r[`WBC_ADDR_W-1:`WBC_BEAT_LSB] ==
			wm_req.addr[`WBC_ADDR_W-1:`WBC_BEAT_LSB];
		wm_load = !wb_valid_r || port_wb;
		// A refill waits for every older write so it cannot read stale memory
		drained = !wb_valid_r && !vb_valid_r && !mem_wr.valid;
		miss_go = state_r == ST_MISS && drained;
		vict_dirty = valid_r[frame_idx(lk_set, vict_way)] && dirty_r[frame_idx(lk_set, vict_way)];
		maint_step = state_r == ST_MAINT && !(hit && hit_dirty && vb_valid_r);
		maint_move = maint_step && hit && hit_dirty;
		vb_load = (miss_go && vict_dirty) || maint_move;
		fill_last = state_r == ST_FILL && fill_valid && fill_beat_r == `WBC_LAST_BEAT;
	end

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (take_maint) begin
					state_nxt = ST_MAINT;
				end else if (take_cpu && !hit && !cpu_req.we) begin
					state_nxt = ST_MISS;
				end else if (wm_active && !wm_merge && !wm_load) begin
					state_nxt = ST_WMISS;
				end
			end
			ST_WMISS: begin
				if (wm_merge || wm_load) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_MISS: begin
				if (miss_go) begin
					state_nxt = ST_FILL;
				end
			end
			ST_FILL: begin
				if (fill_last) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_MAINT: begin
				if (maint_step && m_left_r == `WBC_CNT_W'(1)) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			req_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (take_cpu) begin
				req_r <= cpu_req;
			end
		end
	end

	// Snoops and commands take the free slot first; the CPU waits until every step of the command has finished
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_ready <= 1'b0;
			maint_ready <= 1'b0;
		end else begin
			maint_ready <= state_nxt == ST_IDLE && maint_req.valid;
			cpu_ready <= state_nxt == ST_IDLE && !maint_req.valid;
		end
	end

	// Line state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_r <= '0;
			dirty_r <= '0;
			lru_r <= '0;
		end else begin
			if (rd_hit || wr_hit) begin
				lru_r[lk_set] <= ~hit_way;
			end
			if (wr_hit) begin
				dirty_r[frame_idx(lk_set, hit_way)] <= 1'b1;
			end
			if (miss_go) begin
				valid_r[frame_idx(lk_set, vict_way)] <= 1'b0;
				dirty_r[frame_idx(lk_set, vict_way)] <= 1'b0;
			end
			if (fill_last) begin
				valid_r[frame_idx(req_r.addr[`WBC_TAG_LSB-1:`WBC_SET_LSB], fill_way_r)] <= 1'b1;
				dirty_r[frame_idx(req_r.addr[`WBC_TAG_LSB-1:`WBC_SET_LSB], fill_way_r)] <= 1'b0;
				lru_r[req_r.addr[`WBC_TAG_LSB-1:`WBC_SET_LSB]] <= ~fill_way_r;
			end
			if (maint_step && hit) begin
				dirty_r[frame_idx(lk_set, hit_way)] <= 1'b0;
				if (m_inv_r) begin
					valid_r[frame_idx(lk_set, hit_way)] <= 1'b0;
				end
			end
		end
	end

	// Tag and data storage; no reset needed since valid gates every use
	always_ff @(posedge clk) begin
		if (miss_go) begin
			tag_mem[frame_idx(lk_set, vict_way)] <= lk_tag;
		end
		if (wr_hit) begin
			data_mem[word_idx(lk_set, hit_way, lk_addr[`WBC_SET_LSB-1:`WBC_BEAT_LSB])] <= merge_bytes(
				data_mem[word_idx(lk_set, hit_way, lk_addr[`WBC_SET_LSB-1:`WBC_BEAT_LSB])],
				cpu_req.wdata, cpu_req.be);
		end
		if (state_r == ST_FILL && fill_valid) begin
			data_mem[word_idx(req_r.addr[`WBC_TAG_LSB-1:`WBC_SET_LSB], fill_way_r, fill_beat_r)] <= fill_data;
		end
	end

	// Refill: request goes out in the same cycle the victim leaves, overlapping the writeback
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_rd_valid <= 1'b0;
			mem_rd_addr <= '0;
			fill_beat_r <= '0;
			fill_way_r <= 1'b0;
		end else begin
			if (miss_go) begin
				mem_rd_valid <= 1'b1;
				mem_rd_addr <= {lk_addr[`WBC_ADDR_W-1:`WBC_SET_LSB], `WBC_SET_LSB'(0)};
				fill_beat_r <= '0;
				fill_way_r <= vict_way;
			end else if (mem_rd_ready) begin
				mem_rd_valid <= 1'b0;
			end
			if (state_r == ST_FILL && fill_valid) begin
				fill_beat_r <= fill_beat_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_rvalid <= 1'b0;
			cpu_rdata <= '0;
		end else begin
			cpu_rvalid <= rd_hit || fill_last;
			if (rd_hit) begin
				cpu_rdata <= data_mem[word_idx(lk_set, hit_way, lk_addr[`WBC_SET_LSB-1:`WBC_BEAT_LSB])];
			end else if (state_r == ST_FILL && fill_valid &&
				fill_beat_r == req_r.addr[`WBC_SET_LSB-1:`WBC_BEAT_LSB]) begin
				cpu_rdata <= fill_data;
			end
		end
	end

	// Snoop and writeback engine, one line per step
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			m_addr_r <= '0;
			m_left_r <= '0;
			m_inv_r <= 1'b0;
			m_hit_r <= 1'b0;
			maint_done <= 1'b0;
			maint_hit <= 1'b0;
		end else begin
			maint_done <= 1'b0;
			if (take_maint) begin
				m_addr_r <= maint_req.addr;
				m_left_r <= (maint_req.count == '0) ? `WBC_CNT_W'(1) : maint_req.count;
				m_inv_r <= maint_req.inv;
				m_hit_r <= 1'b0;
			end else if (maint_step) begin
				m_addr_r <= m_addr_r + `WBC_ADDR_W'(`WBC_BEATS * 8);
				m_left_r <= m_left_r - 1'b1;
				m_hit_r <= m_hit_r || hit;
				if (m_left_r == `WBC_CNT_W'(1)) begin
					maint_done <= 1'b1;
					maint_hit <= m_hit_r || hit;
				end
			end
		end
	end

	// Victim buffer frees the frame at once and drains in the background
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vb_valid_r <= 1'b0;
			vb_addr_r <= '0;
			vb_beat_r <= '0;
		end else if (vb_load) begin
			vb_valid_r <= 1'b1;
			vb_beat_r <= '0;
			vb_addr_r <= {tag_mem[frame_idx(lk_set, miss_go ? vict_way : hit_way)], lk_set, `WBC_SET_LSB'(0)};
		end else if (port_free && vb_valid_r) begin
			vb_beat_r <= vb_beat_r + 1'b1;
			if (vb_beat_r == `WBC_LAST_BEAT) begin
				vb_valid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (vb_load) begin
			for (int b = 0; b < `WBC_BEATS; b++) begin
				vb_data_r[b] <= data_mem[word_idx(lk_set, miss_go ? vict_way : hit_way, `WBC_BEAT_W'(b))];
			end
		end
	end

	// Write buffer: one double-word entry, merging same-address write misses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_valid_r <= 1'b0;
			wb_addr_r <= '0;
			wb_data_r <= '0;
			wb_be_r <= '0;
		end else if (wm_active && wm_merge) begin
			wb_data_r <= merge_bytes(wb_data_r, wm_req.wdata, wm_req.be);
			wb_be_r <= wb_be_r | wm_req.be;
		end else if (wm_active && wm_load) begin
			wb_valid_r <= 1'b1;
			wb_addr_r <= {wm_req.addr[`WBC_ADDR_W-1:`WBC_BEAT_LSB], `WBC_BEAT_LSB'(0)};
			wb_data_r <= wm_req.wdata;
			wb_be_r <= wm_req.be;
		end else if (port_wb) begin
			wb_valid_r <= 1'b0;
		end
	end

	// Write port: victim beats go before buffered writes, so a later write to the victim's line reaches memory after it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_wr <= '0;
		end else if (port_free) begin
			if (vb_valid_r) begin
				mem_wr.valid <= 1'b1;
				mem_wr.addr <= {vb_addr_r[`WBC_ADDR_W-1:`WBC_SET_LSB], vb_beat_r, `WBC_BEAT_LSB'(0)};
				mem_wr.data <= vb_data_r[vb_beat_r];
				mem_wr.be <= '1;
			end else if (wb_valid_r) begin
				mem_wr.valid <= 1'b1;
				mem_wr.addr <= wb_addr_r;
				mem_wr.data <= wb_data_r;
				mem_wr.be <= wb_be_r;
			end else begin
				mem_wr.valid <= 1'b0;
			end
		end
	end
endmodule // wbc_cache

// ---- design/wbc_regs.svh ----
// Purpose: constants for the writeback data cache line-state block
// Assumes: two ways, 128 sets, 64-byte lines moved as eight 64-bit beats
// Notes: definitions only
`ifndef WBC_REGS_SVH
`define WBC_REGS_SVH
`define WBC_ADDR_W 32
`define WBC_DW 64
`define WBC_BE_W 8
`define WBC_SET_W 7
`define WBC_TAG_W 19
`define WBC_BEAT_W 3
`define WBC_NSETS 128
`define WBC_NFRAMES 256
`define WBC_NWORDS 2048
`define WBC_BEATS 8
`define WBC_LAST_BEAT 3'h7
`define WBC_BEAT_LSB 3
`define WBC_SET_LSB 6
`define WBC_TAG_LSB 13
`define WBC_CNT_W 8
`endif

// ---- design/wbc_pkg.sv ----
// Purpose: types shared by the cache line-state block and its users
// Assumes: wbc_regs.svh constants
// Notes: none
package wbc_pkg;
`include "wbc_regs.svh"
	typedef logic [`WBC_ADDR_W-1:0] wbc_addr_t;
	typedef logic [`WBC_DW-1:0] wbc_data_t;
	typedef logic [`WBC_BE_W-1:0] wbc_be_t;
	typedef logic [`WBC_SET_W-1:0] wbc_set_t;
	typedef logic [`WBC_TAG_W-1:0] wbc_tag_t;
	typedef logic [`WBC_BEAT_W-1:0] wbc_beat_t;
	typedef logic [`WBC_CNT_W-1:0] wbc_cnt_t;
	typedef struct packed {
		logic valid;
		logic we;
		wbc_addr_t addr;
		wbc_data_t wdata;
		wbc_be_t be;
	} wbc_cpu_req_s;
	typedef struct packed {
		logic valid;
		logic inv;
		wbc_addr_t addr;
		wbc_cnt_t count;
	} wbc_maint_req_s;
	typedef struct packed {
		logic valid;
		wbc_addr_t addr;
		wbc_data_t data;
		wbc_be_t be;
	} wbc_mem_wr_s;
	typedef enum logic [2:0] {ST_IDLE, ST_MISS, ST_FILL, ST_WMISS, ST_MAINT} wbc_state_e;
endpackage

// ---- tb/wbc_props.sv ----
// Purpose: port checker for the cache line-state block
// Assumes: wbc_pkg types, one clock domain
// Notes: bound onto wbc_cache at the foot of this file
`timescale 1ns/1ps
module wbc_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// CPU side
	input wire wbc_pkg::wbc_cpu_req_s cpu_req,
	input wire logic cpu_ready,
	input wire logic cpu_rvalid,
	input wire wbc_pkg::wbc_data_t cpu_rdata,
	// Commands
	input wire wbc_pkg::wbc_maint_req_s maint_req,
	input wire logic maint_ready,
	input wire logic maint_done,
	input wire logic maint_hit,
	// Memory side
	input wire logic mem_rd_valid,
	input wire wbc_pkg::wbc_addr_t mem_rd_addr,
	input wire logic mem_rd_ready,
	input wire logic fill_valid,
	input wire wbc_pkg::wbc_data_t fill_data,
	input wire wbc_pkg::wbc_mem_wr_s mem_wr,
	input wire logic mem_wr_ready
);
	import wbc_pkg::*;
	logic [2:0] beat_r;
	wire rd_take = cpu_req.valid && cpu_ready && !cpu_req.we;
	wire mt_take = maint_req.valid && maint_ready;
	wire last_beat = fill_valid && beat_r == 3'h7;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Beats counted mod 8 so the closing beat of a refill is known
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			beat_r <= 3'h0;
		else if (fill_valid)
			beat_r <= beat_r + 3'h1;
	end
	property p_rd_align;
		mem_rd_valid |-> mem_rd_addr[5:0] == 6'h00;
	endproperty
	a_rd_align: assert property (p_rd_align) else $error("refill not line aligned");
	property p_stall;
		mem_rd_valid |-> !cpu_ready && !maint_ready;
	endproperty
	a_stall: assert property (p_stall) else $error("request taken during refill");
	property p_rd_hold;
		mem_rd_valid && !mem_rd_ready |=> mem_rd_valid && $stable(mem_rd_addr);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("refill request dropped");
	property p_wr_hold;
		mem_wr.valid && !mem_wr_ready |=> mem_wr.valid && $stable(mem_wr);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("memory write dropped");
	property p_rd_ans;
		rd_take |=> cpu_rvalid || !cpu_ready;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read neither answered nor stalled");
	property p_fill_end;
		last_beat |=> cpu_rvalid;
	endproperty
	a_fill_end: assert property (p_fill_end) else $error("no answer after refill");
	property p_mt_done;
		mt_take |=> !maint_done ##[1:600] maint_done;
	endproperty
	a_mt_done: assert property (p_mt_done) else $error("command not finished in time");
	property p_mt_hit;
		$changed(maint_hit) |-> maint_done;
	endproperty
	a_mt_hit: assert property (p_mt_hit) else $error("presence flag moved without done");
endmodule // wbc_props
bind wbc_cache wbc_props u_props (.clk, .rst_n, .cpu_req, .cpu_ready, .cpu_rvalid, .cpu_rdata,
	.maint_req, .maint_ready, .maint_done, .maint_hit, .mem_rd_valid, .mem_rd_addr, .mem_rd_ready,
	.fill_valid, .fill_data, .mem_wr, .mem_wr_ready);

// ---- tb/wbc_mem_model.sv ----
// Purpose: lower-level memory that answers refills and takes writes
// Assumes: requests are held until ready; slow adds random stalls
// Notes: unwritten double-words read back an address pattern
`timescale 1ns/1ps
module wbc_mem_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Mode
	input wire logic slow,
	// Refill
	input wire logic mem_rd_valid,
	input wire wbc_pkg::wbc_addr_t mem_rd_addr,
	output logic mem_rd_ready,
	output logic fill_valid,
	output wbc_pkg::wbc_data_t fill_data,
	// Writes
	input wire wbc_pkg::wbc_mem_wr_s mem_wr,
	output logic mem_wr_ready
);
	import wbc_pkg::*;
	logic [63:0] mem_r [logic [28:0]];
	logic [63:0] tmp;
	logic [28:0] ptr_r;
	logic [3:0] left_r;
	function automatic logic [63:0] rd_dw(logic [28:0] k);
		return mem_r.exists(k) ? mem_r[k] : {k, 6'h2a, k};
	endfunction
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_rd_ready <= 1'b0;
			mem_wr_ready <= 1'b0;
			fill_valid <= 1'b0;
			fill_data <= 64'h0;
			left_r <= 4'h0;
		end else begin
			mem_wr_ready <= !slow || $urandom_range(1);
			mem_rd_ready <= left_r == 4'h0 && !(mem_rd_valid && mem_rd_ready) && (!slow || $urandom_range(1));
			if (mem_wr.valid && mem_wr_ready) begin
				tmp = rd_dw(mem_wr.addr[31:3]);
				for (int i = 0; i < 8; i++)
					if (mem_wr.be[i])
						tmp[8*i +: 8] = mem_wr.data[8*i +: 8];
				mem_r[mem_wr.addr[31:3]] = tmp;
			end
			// Between beats the bus shows junk, the inverse of what it showed the cycle before
			if (left_r != 4'h0 && (!slow || $urandom_range(1))) begin
				fill_valid <= 1'b1;
				fill_data <= rd_dw(ptr_r);
				ptr_r <= ptr_r + 29'h1;
				left_r <= left_r - 4'h1;
			end else begin
				fill_valid <= 1'b0;
				fill_data <= ~fill_data;
			end
			if (mem_rd_valid && mem_rd_ready) begin
				ptr_r <= mem_rd_addr[31:3];
				left_r <= 4'h8;
			end
		end
	end
endmodule // wbc_mem_model

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the cache line-state block
// Assumes: wbc_mem_model sits on the memory side
// Notes: expected data comes from a byte-level reference of memory
`timescale 1ns/1ps
module testbench;
	import wbc_pkg::*;
	logic clk, rst_n, slow, mem_rd_valid, mem_rd_ready, fill_valid, mem_wr_ready;
	logic cpu_ready, cpu_rvalid, maint_ready, maint_done, maint_hit;
	wbc_cpu_req_s cpu_req;
	wbc_maint_req_s maint_req;
	wbc_data_t cpu_rdata, fill_data, tmp;
	wbc_addr_t mem_rd_addr;
	wbc_mem_wr_s mem_wr;
	logic [63:0] ref_r [logic [28:0]];
	int fail_count, cmp_count, rd_cnt, wr_cnt, m0, w0, miss;
	wbc_cache dut (.clk, .rst_n, .cpu_req, .cpu_ready, .cpu_rvalid, .cpu_rdata, .maint_req, .maint_ready,
		.maint_done, .maint_hit, .mem_rd_valid, .mem_rd_addr, .mem_rd_ready, .fill_valid, .fill_data,
		.mem_wr, .mem_wr_ready);
	wbc_mem_model pm (.clk, .rst_n, .slow, .mem_rd_valid, .mem_rd_addr, .mem_rd_ready, .fill_valid,
		.fill_data, .mem_wr, .mem_wr_ready);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (mem_rd_valid && mem_rd_ready)
			rd_cnt++;
		if (mem_wr.valid && mem_wr_ready)
			wr_cnt++;
	end
	function automatic wbc_addr_t ad(int t, int s, int b);
		return {t[18:0], s[6:0], b[2:0], 3'h0};
	endfunction
	function automatic wbc_data_t expv(wbc_addr_t a);
		return ref_r.exists(a[31:3]) ? ref_r[a[31:3]] : {a[31:3], 6'h2a, a[31:3]};
	endfunction
	task automatic chk(logic [64:0] g, logic [64:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_n(int g, int e);
		chk(65'(g), 65'(e));
	endtask
	task automatic print_verdict;
		if (fail_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Quiet means no memory write seen for 16 cycles
	task automatic settle;
		int q = 0;
		for (int k = 0; k < 2000 && q < 16; k++) begin
			@(negedge clk);
			q = mem_wr.valid ? 0 : q + 1;
		end
	endtask
	task automatic cpu(logic we, wbc_addr_t a, wbc_data_t d, wbc_be_t be);
		@(negedge clk);
		m0 = rd_cnt;
		cpu_req = '{1'b1, we, a, d, be};
		while (cpu_ready !== 1'b1)
			@(negedge clk);
		@(negedge clk);
		cpu_req.valid = 1'b0;
		tmp = expv(a);
		for (int i = 0; i < 8; i++)
			if (we && be[i])
				tmp[8*i +: 8] = d[8*i +: 8];
		ref_r[a[31:3]] = tmp;
		if (!we) begin
			for (int n = 0; n < 300 && cpu_rvalid !== 1'b1; n++)
				@(negedge clk);
			chk({cpu_rvalid, cpu_rdata}, {1'b1, tmp});
			miss = rd_cnt - m0;
		end
	endtask
	task automatic mnt(logic inv, wbc_addr_t a, int n, logic eh, int ew);
		@(negedge clk);
		w0 = wr_cnt;
		maint_req = '{1'b1, inv, a, n[7:0]};
		while (maint_ready !== 1'b1)
			@(negedge clk);
		@(negedge clk);
		maint_req.valid = 1'b0;
		for (int k = 0; k < 900 && maint_done !== 1'b1; k++)
			@(negedge clk);
		chk({maint_done, maint_hit}, {1'b1, eh});
		settle;
		chk_n(wr_cnt - w0, ew);
	endtask
	initial begin
		cpu_req = '0;
		maint_req = '0;
		slow = 1'b0;
		rst_n = 1'b0;
		void'($urandom(32'h9d5c));
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		cpu(0, ad(1, 5, 0), 0, 0);
		cpu(0, ad(2, 5, 1), 0, 0);
		cpu(0, ad(1, 5, 2), 0, 0);
		chk_n(miss, 0);
		cpu(0, ad(3, 5, 3), 0, 0);
		cpu(0, ad(1, 5, 4), 0, 0);
		chk_n(miss, 0);
		w0 = wr_cnt;
		cpu(1, ad(1, 5, 2), 64'h1122334455667788, 8'h3c);
		settle;
		chk_n(wr_cnt - w0, 0);
		cpu(0, ad(3, 5, 0), 0, 0);
		chk_n(miss, 0);
		w0 = wr_cnt;
		cpu(0, ad(2, 5, 0), 0, 0);
		settle;
		chk_n(wr_cnt - w0, 8);
		cpu(0, ad(1, 5, 2), 0, 0);
		chk_n(miss, 1);
		cpu(1, ad(7, 9, 1), 64'ha5, 8'h01);
		chk(cpu_ready, 1);
		cpu(1, ad(7, 9, 1), 64'h5a00, 8'h02);
		settle;
		cpu(0, ad(7, 9, 1), 0, 0);
		chk_n(miss, 1);
		cpu(1, ad(1, 5, 0), 64'hdead, 8'hff);
		// Two write misses arrive while the victim buffer drains, so they merge: 8 beats plus one write
		fork
			mnt(0, ad(1, 5, 0), 1, 1, 9);
			begin
				repeat (2) @(negedge clk);
				cpu(1, ad(6, 12, 2), 64'h11, 8'h01);
				cpu(1, ad(6, 12, 2), 64'h2200, 8'h02);
			end
		join
		cpu(0, ad(6, 12, 2), 0, 0);
		chk_n(miss, 1);
		mnt(0, ad(1, 5, 0), 1, 1, 0);
		cpu(0, ad(1, 5, 0), 0, 0);
		chk_n(miss, 0);
		cpu(0, ad(1, 6, 0), 0, 0);
		cpu(1, ad(1, 5, 3), 64'hbeef, 8'h0f);
		mnt(1, ad(1, 5, 0), 2, 1, 8);
		cpu(0, ad(1, 6, 0), 0, 0);
		chk_n(miss, 1);
		cpu(0, ad(1, 5, 3), 0, 0);
		chk_n(miss, 1);
		mnt(1, ad(9, 40, 0), 1, 0, 0);
		// A zero count covers one line only; set 6 holds a tag 1 line, which even a count of 2 from this tag 2 address would keep
		mnt(1, ad(2, 5, 0), 0, 1, 0);
		cpu(0, ad(1, 6, 0), 0, 0);
		chk_n(miss, 0);
		slow = 1'b1;
		repeat (300)
			cpu(1'($urandom_range(1)), ad($urandom_range(3), $urandom_range(1), $urandom_range(7)),
				{$urandom, $urandom}, 8'($urandom));
		print_verdict;
	end
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		print_verdict;
	end
endmodule // testbench
